// File: logic/mrc_host.sv
// Host that reads a multiplexed-address ROM through its pins.
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// Functional notes
// - Sixteen-bit address sent as two bytes.
// - High byte driven first during strobe.
// - Low byte only after strobe ends.
// - Chain outputs may disable RAM chips.
module mrc_host #(
   parameter logic STROBE_ACT  = 1'b1,
   parameter logic SEL_ONE_ACT = 1'b1,
   parameter logic SEL_TWO_ACT = 1'b1,
   parameter int   ACCESS_CYC  = mrc_pkg::MRC_ACCESS_CYC
) (
   input  wire logic              sys_clk,
   input  wire logic              reset_n,
   input  wire logic              req_valid,
   output logic                   req_ready,
   input  wire mrc_pkg::mrc_req_s req,
   output logic                   rsp_valid,
   output mrc_pkg::mrc_rsp_s      rsp,
   output logic [7:0]             shared_address_lines,
   output logic                   address_strobe,
   output logic                   select_one,
   output logic                   select_two,
   output logic                   read_strobe_n,
   input  wire logic [7:0]        data_lines_in,
   input  wire logic              chain_enable_output
);
   import mrc_pkg::*;

   mrc_state_e            state_reg, state_next;
   logic [MRC_CNT_W-1:0]  cnt_reg, cnt_next;
   logic [15:0]           addr_reg;
   logic [7:0]            high_byte;
   logic [MRC_CNT_W-1:0]  since_strobe_reg;
   logic                  rsp_valid_reg;
   mrc_rsp_s              rsp_reg;
   logic                  done;
   logic                  take;

   assign take      = req_valid && (state_reg == MRC_IDLE);
   // The first setup cycle already shows the new high byte, so the full
   // setup time is spent on the right address.
   assign high_byte = take ? req.addr[15:8] : addr_reg[15:8];
   assign req_ready = (state_reg == MRC_IDLE);
   assign done      = (cnt_reg == '0);
   assign rsp_valid = rsp_valid_reg;
   assign rsp       = rsp_reg;

   always_comb begin
      state_next = state_reg;
      cnt_next   = done ? cnt_reg : cnt_reg - 1'b1;
      unique case (state_reg)
         MRC_IDLE: begin
            if (req_valid) begin
               state_next = MRC_SETUP;
               cnt_next   = MRC_CNT_W'(MRC_SETUP_CYC - 1);
            end
         end
         MRC_SETUP: begin
            if (done) begin
               state_next = MRC_STROBE;
               cnt_next   = MRC_CNT_W'(MRC_STROBE_CYC - 1);
            end
         end
         MRC_STROBE: begin
            if (done) begin
               state_next = MRC_HOLD;
               cnt_next   = MRC_CNT_W'(MRC_HOLD_CYC - 1);
            end
         end
         MRC_HOLD: begin
            if (done) begin
               state_next = MRC_ACCESS;
               cnt_next   = MRC_CNT_W'(ACCESS_CYC - 1);
            end
         end
         MRC_ACCESS: begin
            if (done) begin
               state_next = MRC_IDLE;
            end
         end
      endcase
   end

   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         state_reg <= MRC_IDLE;
         cnt_reg   <= '0;
         addr_reg  <= 16'h0000;
      end else begin
         state_reg <= state_next;
         cnt_reg   <= cnt_next;
         if (take) begin
            addr_reg <= req.addr;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Pin drive. The low byte waits out the hold time so the device's latch
   // closes on a stable high byte.
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         shared_address_lines <= MRC_LINES_RST;
         address_strobe       <= ~STROBE_ACT;
         select_one           <= ~SEL_ONE_ACT;
         select_two           <= ~SEL_TWO_ACT;
         read_strobe_n        <= 1'b1;
      end else begin
         unique case (state_next)
            MRC_SETUP, MRC_STROBE:
               shared_address_lines <= high_byte;
            MRC_HOLD:
               shared_address_lines <= high_byte;
            MRC_ACCESS:
               shared_address_lines <= addr_reg[7:0];
            default:
               shared_address_lines <= shared_address_lines;
         endcase
         address_strobe <= (state_next == MRC_STROBE) ? STROBE_ACT
                                                      : ~STROBE_ACT;
         select_one <= (state_next != MRC_IDLE) ? SEL_ONE_ACT
                                                : ~SEL_ONE_ACT;
         select_two <= (state_next != MRC_IDLE) ? SEL_TWO_ACT
                                                : ~SEL_TWO_ACT;
         read_strobe_n <= (state_next != MRC_ACCESS);
      end
   end

   // The device array is static, so data is sampled only once after access.
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         rsp_valid_reg <= 1'b0;
         rsp_reg       <= '0;
      end else begin
         rsp_valid_reg <= (state_reg == MRC_ACCESS) && done;
         if ((state_reg == MRC_ACCESS) && done) begin
            rsp_reg.data  <= data_lines_in;
            rsp_reg.chain <= chain_enable_output;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   sequence s_strobe_end;
      $fell(address_strobe == STROBE_ACT);
   endsequence

   sequence s_strobe_start;
      $rose(address_strobe == STROBE_ACT);
   endsequence

   sequence s_read_start;
      $fell(read_strobe_n);
   endsequence

   a_high_before_strobe: assert property (
      @(posedge sys_clk) disable iff (!reset_n)
      $rose(address_strobe == STROBE_ACT)
         |-> shared_address_lines == addr_reg[15:8])
      else $error("high byte not on lines at strobe start");

   a_low_after_strobe: assert property (
      @(posedge sys_clk) disable iff (!reset_n)
      s_strobe_end |-> (shared_address_lines == addr_reg[15:8]) [*8])
      else $error("low byte appeared before hold ended");

   a_strobe_width: assert property (
      @(posedge sys_clk) disable iff (!reset_n)
      $rose(address_strobe == STROBE_ACT)
         |-> (address_strobe == STROBE_ACT) [*8])
      else $error("strobe pulse too short");

   a_read_low_addr: assert property (
      @(posedge sys_clk) disable iff (!reset_n)
      !read_strobe_n |-> shared_address_lines == addr_reg[7:0])
      else $error("read active without low byte");

   a_read_selected: assert property (
      @(posedge sys_clk) disable iff (!reset_n)
      !read_strobe_n |-> select_one == SEL_ONE_ACT
         && select_two == SEL_TWO_ACT)
      else $error("read active while deselected");

   a_no_strobe_read: assert property (
      @(posedge sys_clk) disable iff (!reset_n)
      address_strobe == STROBE_ACT |-> read_strobe_n)
      else $error("read overlaps strobe");

   a_rsp_after_read: assert property (
      @(posedge sys_clk) disable iff (!reset_n)
      rsp_valid |-> $past(!read_strobe_n))
      else $error("answer without read phase");

   a_ready_idle: assert property (
      @(posedge sys_clk) disable iff (!reset_n)
      rsp_valid |-> req_ready)
      else $error("not ready after answer");

   a_setup_before_strobe: assert property (
      @(posedge sys_clk) disable iff (!reset_n)
      s_strobe_start |-> $past(shared_address_lines, 8)
         == shared_address_lines)
      else $error("high byte not settled before strobe");

   ////////////////////////////////////////////////////////////////////////////
   // Hold helper. The hold time is far longer than a repetition may count,
   // so the cycles since the strobe last ended are kept in a counter.
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         since_strobe_reg <= '0;
      end else if (address_strobe == STROBE_ACT) begin
         since_strobe_reg <= '0;
      end else if (since_strobe_reg != '1) begin
         since_strobe_reg <= since_strobe_reg + 1'b1;
      end
   end

   a_hold_before_low: assert property (
      @(posedge sys_clk) disable iff (!reset_n)
      s_read_start |-> since_strobe_reg >= MRC_CNT_W'(MRC_HOLD_CYC))
      else $error("low byte sent before hold ended");

   a_rsp_holds: assert property (
      @(posedge sys_clk) disable iff (!reset_n)
      !rsp_valid |-> $stable(rsp))
      else $error("answer changed between reads");
endmodule

// File: logic/mrc_pkg.sv
// Package for the multiplexed-address ROM read controller.
package mrc_pkg;
   // Bus widths.
   localparam int MRC_ADDR_W = 16;
   localparam int MRC_LINE_W = 8;
   // Timing in ns, and the cycle counts at 4 ns, always rounded up.
   localparam int MRC_CLK_NS      = 4;
   localparam int MRC_STROBE_NS   = 200;
   localparam int MRC_SETUP_NS    = 75;
   localparam int MRC_HOLD_NS     = 150;
   localparam int MRC_ACCESS_NS   = 1000;
   localparam int MRC_STROBE_CYC  = (MRC_STROBE_NS + MRC_CLK_NS - 1) / MRC_CLK_NS;
   localparam int MRC_SETUP_CYC   = (MRC_SETUP_NS + MRC_CLK_NS - 1) / MRC_CLK_NS;
   localparam int MRC_HOLD_CYC    = (MRC_HOLD_NS + MRC_CLK_NS - 1) / MRC_CLK_NS;
   localparam int MRC_ACCESS_CYC  = (MRC_ACCESS_NS + MRC_CLK_NS - 1) / MRC_CLK_NS;
   localparam int MRC_CNT_W       = 9;
   // Reset value of the shared address lines.
   localparam logic [7:0] MRC_LINES_RST = 8'h00;

   typedef enum logic [2:0] {
      MRC_IDLE, MRC_SETUP, MRC_STROBE, MRC_HOLD, MRC_ACCESS
   } mrc_state_e;

   typedef struct packed {
      logic [15:0] addr;
   } mrc_req_s;

   typedef struct packed {
      logic [7:0] data;
      logic       chain;
   } mrc_rsp_s;
endpackage

// File: tb/mrc_rom_model.sv
// Behavioural model of the multiplexed-address mask ROM.
`timescale 1ns/1ps
module mrc_rom_model #(
   parameter logic [15:0] BASE         = 16'h4000,
   parameter logic        LARGE        = 1'b0,
   parameter logic        STROBE_ACT   = 1'b1,
   parameter logic        SEL_ONE_ACT  = 1'b1,
   parameter logic        SEL_TWO_ACT  = 1'b1,
   parameter logic        CHAIN_IN_ACT = 1'b1
) (
   input  wire logic [7:0] shared_address_lines,
   input  wire logic       address_strobe,
   input  wire logic       select_one,
   input  wire logic       select_two,
   input  wire logic       read_strobe_n,
   input  wire logic       chain_enable_input,
   output logic [7:0]      data_lines,
   output logic            chain_enable_output
);
   logic [7:0]  high_reg = 8'h00;
   wire  [15:0] word_addr = {high_reg, shared_address_lines};
   wire         match = LARGE ? (word_addr[15:10] == BASE[15:10])
                              : (word_addr[15:9] == BASE[15:9]);
   wire         sel = match && (select_one == SEL_ONE_ACT)
                      && (select_two == SEL_TWO_ACT);
   // Only the larger variant has a chain input.
   wire         chained = LARGE
                          && (chain_enable_input == CHAIN_IN_ACT);
   wire  [7:0]  word = word_addr[7:0] ^ word_addr[15:8] ^ 8'h5a;
   // Trailing edge of the strobe in either polarity; held until the next.
   always @(address_strobe) begin
      if (address_strobe !== STROBE_ACT) high_reg = shared_address_lines;
   end
   // A released bus shows the inverse so a late sample cannot pass.
   always @* begin
      if (sel && !read_strobe_n) data_lines = word;
      else data_lines = ~word;
   end
   assign chain_enable_output = sel || chained;
endmodule

// File: tb/testbench.sv
// Self-checking bench for the multiplexed-address ROM host.
`timescale 1ns/1ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin err_total++; \
   $display("Error %0t: got %h want %h", $time, a, b); end end
module testbench;
   import mrc_pkg::*;
   logic sys_clk = 1'b0, reset_n = 1'b0, req_valid = 1'b0;
   logic req_ready, rsp_valid, address_strobe, select_one, select_two;
   logic read_strobe_n, chain_enable_output;
   logic [7:0] shared_address_lines, data_lines;
   mrc_req_s req = '0;
   mrc_rsp_s rsp;
   logic req_ready_b, rsp_valid_b, strobe_b, sel_one_b, sel_two_b;
   logic read_b_n, chain_b;
   logic [7:0] lines_b, data_b;
   mrc_rsp_s rsp_b;
   logic [15:0] cur = 16'h0000, seed = 16'd19005;
   int err_total = 0, checked = 0, cyc = 0;
   always #2 sys_clk = ~sys_clk;
   mrc_host #(.ACCESS_CYC(4)) uut (.sys_clk(sys_clk), .reset_n(reset_n),
      .req_valid(req_valid), .req_ready(req_ready), .req(req),
      .rsp_valid(rsp_valid), .rsp(rsp),
      .shared_address_lines(shared_address_lines),
      .address_strobe(address_strobe), .select_one(select_one),
      .select_two(select_two), .read_strobe_n(read_strobe_n),
      .data_lines_in(data_lines), .chain_enable_output(chain_enable_output));
   mrc_rom_model rom (.shared_address_lines(shared_address_lines),
      .address_strobe(address_strobe), .select_one(select_one),
      .select_two(select_two), .read_strobe_n(read_strobe_n),
      .chain_enable_input(1'b0), .data_lines(data_lines),
      .chain_enable_output(chain_enable_output));
   // Second pair with the address strobe and both select polarities inverted; the read strobe stays active low.
   mrc_host #(.STROBE_ACT(1'b0), .SEL_ONE_ACT(1'b0), .SEL_TWO_ACT(1'b0),
      .ACCESS_CYC(4)) uut_inv (.sys_clk(sys_clk), .reset_n(reset_n),
      .req_valid(req_valid), .req_ready(req_ready_b), .req(req),
      .rsp_valid(rsp_valid_b), .rsp(rsp_b),
      .shared_address_lines(lines_b), .address_strobe(strobe_b),
      .select_one(sel_one_b), .select_two(sel_two_b),
      .read_strobe_n(read_b_n), .data_lines_in(data_b),
      .chain_enable_output(chain_b));
   mrc_rom_model #(.STROBE_ACT(1'b0), .SEL_ONE_ACT(1'b0),
      .SEL_TWO_ACT(1'b0)) rom_inv (.shared_address_lines(lines_b),
      .address_strobe(strobe_b), .select_one(sel_one_b),
      .select_two(sel_two_b), .read_strobe_n(read_b_n),
      .chain_enable_input(1'b0), .data_lines(data_b),
      .chain_enable_output(chain_b));
   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   function automatic logic [7:0] exp_word(input logic [15:0] a);
      return a[7:0] ^ a[15:8] ^ 8'h5a;
   endfunction
   task automatic print_verdict();
      $display("Checks %0d, errors %0d", checked, err_total);
      if (err_total == 0 && checked > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   always @(negedge sys_clk) begin
      cyc++;
      if (reset_n && address_strobe) `CHK(shared_address_lines, cur[15:8])
      if (reset_n && !read_strobe_n) begin
         `CHK(shared_address_lines, cur[7:0])
         `CHK({select_one, select_two}, 2'b11)
      end
      if (cyc > 20000) begin
         err_total++;
         print_verdict();
      end
   end
   task automatic rd(input logic [15:0] a);
      int n;
      logic in_area;
      n = 0;
      in_area = (a[15:9] == 7'h20);
      cur = a;
      req.addr = a;
      req_valid = 1'b1;
      @(negedge sys_clk);
      req_valid = 1'b0;
      `CHK({req_ready, req_ready_b}, 2'b00)
      while (rsp_valid !== 1'b1 && n < 400) begin
         @(negedge sys_clk);
         n++;
      end
      `CHK({rsp_valid, rsp_valid_b}, 2'b11)
      `CHK({rsp.chain, rsp_b.chain}, {2{in_area}})
      if (in_area) `CHK({rsp.data, rsp_b.data}, {2{exp_word(a)}})
   endtask
   initial begin
      repeat (3) @(negedge sys_clk);
      reset_n = 1'b1;
      // Area edges first, then back-to-back random reads in and out.
      rd(16'h4000);
      rd(16'h41ff);
      rd(16'h4200);
      rd(16'h3fff);
      rd(16'h41a5);
      // A reset in the middle of the strobe must idle every pin at once.
      cur = 16'h4123;
      req.addr = 16'h4123;
      req_valid = 1'b1;
      @(negedge sys_clk);
      req_valid = 1'b0;
      repeat (30) @(negedge sys_clk);
      reset_n = 1'b0;
      @(negedge sys_clk);
      `CHK({address_strobe, select_one, select_two, read_strobe_n}, 4'h1)
      `CHK({strobe_b, sel_one_b, sel_two_b, read_b_n}, 4'hf)
      `CHK({req_ready, rsp_valid, rsp, shared_address_lines}, 19'h40000)
      reset_n = 1'b1;
      rd(16'h4123);
      for (int i = 0; i < 16; i++) begin
         seed = lfsr(seed);
         rd({seed[0] ? 7'h20 : seed[15:9], seed[8:0]});
      end
      print_verdict();
   end
endmodule
